// ==== core/sps_pkg.sv ====
// Purpose: shared constants and types of the supply supervisor and watchdog
// Assumes: 50 MHz core clock
// Notes:   long counts are derived here and overridable on the top module
package sps_pkg;

  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  // reset hold after the last cause clears, in ms
  localparam int unsigned RST_HOLD_MS   = 200;
  // nominal watchdog timeout in ms (1.6 s, window 1.0 .. 2.25 s)
  localparam int unsigned WDOG_MS       = 1600;
  localparam int unsigned RST_HOLD_CYC  = (CLK_HZ / MS_PER_S) * RST_HOLD_MS;
  localparam int unsigned WDOG_CYC      = (CLK_HZ / MS_PER_S) * WDOG_MS;

  // wide enough for 80e6 cycles
  localparam int unsigned CNT_W         = 27;
  localparam int unsigned SYNC_W        = 5;

  // synchroniser lane positions
  localparam int unsigned SY_MR         = 0;
  localparam int unsigned SY_SUPPLY     = 1;
  localparam int unsigned SY_KICK       = 2;
  localparam int unsigned SY_FLOAT      = 3;
  localparam int unsigned SY_PSENSE     = 4;

  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h01;

  typedef enum logic [2:0] {
    ST_ASSERT = 3'h1,
    ST_HOLD   = 3'h2,
    ST_RUN    = 3'h4
  } sps_rst_state_t;

endpackage : sps_pkg

// ==== core/sps_wdog_if.sv ====
// Purpose: carrier between the supervisor top and its watchdog timer
// Assumes: all members synchronous to core_clk_in
// Notes:   inputs already synchronised by the top
`timescale 1ns/1ps
`default_nettype none
interface sps_wdog_if;
  logic kick;
  logic kick_float;
  logic supply_low;
  logic expired_n;

  modport ctl (output kick, output kick_float, output supply_low, input expired_n);
  modport tmr (input kick, input kick_float, input supply_low, output expired_n);
endinterface : sps_wdog_if
`default_nettype wire

// ==== core/sps_sync.sv ====
// Purpose: two-flop synchroniser, one lane per asynchronous input
// Assumes: lanes are independent levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module sps_sync
  import sps_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [SYNC_W-1:0] async_in,
  output var  logic [SYNC_W-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_lane
      logic meta_ff;
      logic nxt_meta;
      logic nxt_sync;

      always_comb begin
        nxt_meta = async_in[gi];
        nxt_sync = meta_ff;
      end

      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_ff      <= SYNC_RST[gi];
          sync_out[gi] <= SYNC_RST[gi];
        end else begin
          meta_ff      <= nxt_meta;
          sync_out[gi] <= nxt_sync;
        end
      end
    end
  endgenerate

endmodule // sps_sync
`default_nettype wire

// ==== core/sps_wdog.sv ====
// Purpose: watchdog timer restarted by any kick edge
// Assumes: interface inputs already synchronised
// Notes:   expiry only drives expired_n; it never resets the system itself
`timescale 1ns/1ps
`default_nettype none
module sps_wdog
  import sps_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_CYC
) (
  input  wire logic   core_clk_in,
  input  wire logic   rst_n_in,
  sps_wdog_if.tmr     wd
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             kick_prev_ff;
  logic             sup_prev_ff;
  logic             exp_n_ff;
  logic             nxt_exp_n;
  logic             kick_edge;

  assign kick_edge = wd.kick ^ kick_prev_ff;

  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_exp_n = exp_n_ff;
    if (wd.supply_low) begin
      nxt_cnt   = '0;
      nxt_exp_n = 1'b0;
    end else if (kick_edge || wd.kick_float || sup_prev_ff) begin
      nxt_cnt   = '0;
      nxt_exp_n = 1'b1;
    end else if (cnt_ff == CNT_W'(WDOG_CYCLES - 1)) begin
      nxt_exp_n = 1'b0;
    end else begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff       <= '0;
      kick_prev_ff <= 1'b0;
      sup_prev_ff  <= 1'b0;
      exp_n_ff     <= 1'b1;
    end else begin
      cnt_ff       <= nxt_cnt;
      kick_prev_ff <= wd.kick;
      sup_prev_ff  <= wd.supply_low;
      exp_n_ff     <= nxt_exp_n;
    end
  end

  assign wd.expired_n = exp_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  a_kick_restart: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (kick_edge && !wd.supply_low) |=> (cnt_ff == '0) && exp_n_ff)
    else $error("kick edge did not restart watchdog");

  a_quiet_expiry: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (cnt_ff == CNT_W'(WDOG_CYCLES - 1)) && !kick_edge && !wd.kick_float && !wd.supply_low
      && !sup_prev_ff |=> !exp_n_ff)
    else $error("watchdog did not expire after timeout");

  a_supply_low_wdo: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wd.supply_low |=> !exp_n_ff ##1 (!exp_n_ff || !$past(wd.supply_low)))
    else $error("watchdog output not low with supply low");

  a_float_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (wd.kick_float && !wd.supply_low) |=> exp_n_ff && (cnt_ff == '0))
    else $error("floating kick did not disable watchdog");

endmodule // sps_wdog
`default_nettype wire

// ==== core/sps_supervisor.sv ====
// Purpose: supply supervisor with reset hold, watchdog and power warning
// Assumes: 50 MHz free-running time base, no bus, all pins asynchronous
// Notes:   hold and timeout counts are parameters so a bench can shrink them
//
// Function
// - manual reset low asserts system reset
// - supply low asserts system reset
// - hold reset 200 ms after causes clear
// - active-high reset is complement of low
// - any kick edge restarts the watchdog
// - kick quiet past timeout drives expired low
// - expired low while supply below threshold
// - floating kick disables watchdog
// - watchdog expiry never resets system itself
// - power warning follows the sense comparator
// - power warning path independent of others
// - watchdog timeout 1.6 s nominal
`timescale 1ns/1ps
`default_nettype none
module sps_supervisor
  import sps_pkg::*;
#(
  parameter int unsigned RST_HOLD_CYCLES = RST_HOLD_CYC,
  parameter int unsigned WDOG_CYCLES     = WDOG_CYC
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic manual_rst_n_in,
  input  wire logic supply_low_in,
  input  wire logic wdog_kick_in,
  input  wire logic wdog_kick_float_in,
  input  wire logic power_sense_in,
  output var  logic sys_rst_n_out,
  output var  logic sys_rst_out,
  output var  logic wdog_expired_n_out,
  output var  logic power_warn_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_s;
  logic              mr_s;
  logic              supply_s;
  logic              psense_s;
  logic              rst_cause;

  always_comb begin
    raw_in            = '0;
    raw_in[SY_MR]     = manual_rst_n_in;
    raw_in[SY_SUPPLY] = supply_low_in;
    raw_in[SY_KICK]   = wdog_kick_in;
    raw_in[SY_FLOAT]  = wdog_kick_float_in;
    raw_in[SY_PSENSE] = power_sense_in;
  end

  sps_sync u_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .async_in    (raw_in),
    .sync_out    (sync_s)
  );

  assign mr_s     = sync_s[SY_MR];
  assign supply_s = sync_s[SY_SUPPLY];
  assign psense_s = sync_s[SY_PSENSE];

  assign rst_cause = supply_s | ~mr_s;

  ////////////////////////////////////////////////////////////////////////////
  // reset hold state machine
  sps_rst_state_t   state_ff;
  sps_rst_state_t   nxt_state;
  logic [CNT_W-1:0] hold_cnt_ff;
  logic [CNT_W-1:0] nxt_hold_cnt;
  logic             sys_rst_n_ff;
  logic             sys_rst_ff;
  logic             nxt_rst_n;

  always_comb begin
    nxt_state    = state_ff;
    nxt_hold_cnt = hold_cnt_ff;
    if (rst_cause) begin
      nxt_state    = ST_ASSERT;
      nxt_hold_cnt = '0;
    end else begin
      case (state_ff)
        ST_ASSERT: begin
          nxt_state    = ST_HOLD;
          nxt_hold_cnt = '0;
        end
        ST_HOLD: begin
          if (hold_cnt_ff == CNT_W'(RST_HOLD_CYCLES - 1)) begin
            nxt_state = ST_RUN;
          end else begin
            nxt_hold_cnt = hold_cnt_ff + CNT_W'(1);
          end
        end
        ST_RUN: begin
          nxt_state = ST_RUN;
        end
        default: begin
          nxt_state    = ST_ASSERT;
          nxt_hold_cnt = '0;
        end
      endcase
    end
    nxt_rst_n = (nxt_state == ST_RUN);
  end

  // power-up counts as a cause, so the hold also runs after reset release
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff     <= ST_ASSERT;
      hold_cnt_ff  <= '0;
      sys_rst_n_ff <= 1'b0;
      sys_rst_ff   <= 1'b1;
    end else begin
      state_ff     <= nxt_state;
      hold_cnt_ff  <= nxt_hold_cnt;
      sys_rst_n_ff <= nxt_rst_n;
      sys_rst_ff   <= ~nxt_rst_n;
    end
  end

  assign sys_rst_n_out = sys_rst_n_ff;
  assign sys_rst_out   = sys_rst_ff;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  sps_wdog_if wd_if ();

  assign wd_if.kick       = sync_s[SY_KICK];
  assign wd_if.kick_float = sync_s[SY_FLOAT];
  assign wd_if.supply_low = supply_s;

  sps_wdog #(
    .WDOG_CYCLES (WDOG_CYCLES)
  ) u_wdog (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .wd          (wd_if.tmr)
  );

  assign wdog_expired_n_out = wd_if.expired_n;

  ////////////////////////////////////////////////////////////////////////////
  // power warning: shares nothing but clock and reset with the rest
  logic pwarn_n_ff;
  logic nxt_pwarn_n;

  always_comb begin
    nxt_pwarn_n = psense_s;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwarn_n_ff <= 1'b0;
    end else begin
      pwarn_n_ff <= nxt_pwarn_n;
    end
  end

  assign power_warn_n_out = pwarn_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_hold_end;
    (state_ff == ST_HOLD) && (hold_cnt_ff == CNT_W'(RST_HOLD_CYCLES - 1)) && !rst_cause;
  endsequence

  sequence s_release;
    sys_rst_n_out && !sys_rst_out;
  endsequence

  a_manual_assert: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !mr_s |=> !sys_rst_n_out)
    else $error("manual reset did not assert system reset");

  a_supply_assert: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    supply_s |=> !sys_rst_n_out)
    else $error("supply low did not assert system reset");

  a_hold_release: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_hold_end |=> s_release)
    else $error("reset not released at end of hold");

  a_hold_length: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(sys_rst_n_out) |-> ($past(state_ff) == ST_HOLD)
      && ($past(hold_cnt_ff) == CNT_W'(RST_HOLD_CYCLES - 1)))
    else $error("reset released before hold time");

  a_rst_complement: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sys_rst_out == !sys_rst_n_out)
    else $error("reset outputs not complementary");

  a_wdog_no_reset: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (sys_rst_n_out && !rst_cause) |=> sys_rst_n_out)
    else $error("system reset asserted without cause");

  a_power_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ##1 (power_warn_n_out == $past(psense_s)))
    else $error("power warning does not follow sense");

  a_power_indep: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (psense_s == $past(psense_s)) && $changed(sys_rst_n_out) |-> $stable(power_warn_n_out))
    else $error("power warning disturbed by reset logic");

  ////////////////////////////////////////////////////////////////////////////
  // hold machine internals: these pin down each step of the release walk,
  // so a broken counter shows up here before the pins look wrong
  sequence s_cause_gone;
    (state_ff == ST_ASSERT) && !rst_cause;
  endsequence

  sequence s_hold_start;
    (state_ff == ST_HOLD) && (hold_cnt_ff == '0);
  endsequence

  sequence s_hold_step;
    (state_ff == ST_HOLD) && !rst_cause && (hold_cnt_ff != CNT_W'(RST_HOLD_CYCLES - 1));
  endsequence

  sequence s_asserted;
    !sys_rst_n_out && sys_rst_out;
  endsequence

  a_state_onehot: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $onehot(state_ff))
    else $error("reset state not one-hot");

  a_hold_range: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    hold_cnt_ff <= CNT_W'(RST_HOLD_CYCLES - 1))
    else $error("hold counter out of range");

  a_hold_start: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_cause_gone |=> s_hold_start)
    else $error("hold did not start from zero");

  a_hold_step: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_hold_step |=> (hold_cnt_ff == $past(hold_cnt_ff) + CNT_W'(1)) && s_asserted)
    else $error("hold counter did not advance");

  // any cause restarts the whole hold
  a_cause_restart: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rst_cause |=> (state_ff == ST_ASSERT) && (hold_cnt_ff == '0) && s_asserted)
    else $error("cause did not restart hold");

  // outputs track the run state only
  a_out_state: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    sys_rst_n_out == (state_ff == ST_RUN))
    else $error("reset output disagrees with state");

  // released reset stays released with no cause
  a_release_keep: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_release and (!rst_cause) |=> s_release)
    else $error("released reset dropped without cause");

  // warning moves only with the sense lane
  a_power_source: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $changed(power_warn_n_out) |-> (power_warn_n_out == $past(psense_s)))
    else $error("power warning changed without sense");

endmodule // sps_supervisor
`default_nettype wire

// ==== tb/sps_host_model.sv ====
// Purpose: host side model that kicks the watchdog and may tie expiry to manual reset
// Assumes: kick edges launched on falling clock edges, GAP cycles apart
// Notes:   GAP stays above the 2-cycle synchroniser window so no kick is lost
`timescale 1ns/1ps
`default_nettype none
module sps_host_model #(
  parameter int unsigned GAP = 8
) (
  input  wire logic core_clk_in,
  input  wire logic kick_en_in,
  input  wire logic tie_exp_in,
  input  wire logic man_n_in,
  input  wire logic exp_n_in,
  output var  logic kick_out,
  output var  logic man_n_out
);
  int unsigned cnt = 0;

  initial kick_out = 1'h0;

  always @(negedge core_clk_in) begin
    if (kick_en_in) begin
      cnt = (cnt + 1) % GAP;
      if (cnt == 0) kick_out <= ~kick_out;
    end
  end

  assign man_n_out = man_n_in & (exp_n_in | ~tie_exp_in);
endmodule // sps_host_model
`default_nettype wire

// ==== tb/supply_supervisor_watchdog_tb.sv ====
// Purpose: self-checking bench of the supply supervisor and watchdog
// Assumes: shortened hold and timeout counts, inputs driven on falling edges
// Notes:   margins of a few cycles absorb the 2-flop input synchroniser
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_tb;
  import sps_pkg::*;
  localparam int unsigned HOLD = 20;
  localparam int unsigned WDT  = 40;

  typedef struct {
    logic man; logic sup; logic sen; int wt; logic rs; logic ex; logic wn;
  } sps_row_t;

  logic     clk;
  logic     rst_n    = 1'h0;
  logic     man_n    = 1'h1;
  logic     sup_low  = 1'h0;
  logic     flt      = 1'h0;
  logic     sense    = 1'h1;
  logic     kick_en  = 1'h1;
  logic     tie      = 1'h0;
  logic     kick, man_q, rst_n_o, rst_o, exp_n_o, warn_n_o, lv;
  int       fails    = 0;
  int       num_checks = 0;
  sps_row_t rows[8]  = '{
    '{1,0,1,30,1,1,1}, '{0,0,1,4,0,1,1}, '{1,0,1,5,0,1,1}, '{1,0,1,25,1,1,1},
    '{1,0,0,4,1,1,0}, '{1,1,0,4,0,0,0}, '{1,0,1,4,0,1,1}, '{1,0,1,25,1,1,1}};

  sps_host_model #(.GAP(8)) host (
    .core_clk_in(clk), .kick_en_in(kick_en), .tie_exp_in(tie), .man_n_in(man_n),
    .exp_n_in(exp_n_o), .kick_out(kick), .man_n_out(man_q));

  sps_supervisor #(.RST_HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDT)) dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .manual_rst_n_in(man_q),
    .supply_low_in(sup_low), .wdog_kick_in(kick), .wdog_kick_float_in(flt),
    .power_sense_in(sense), .sys_rst_n_out(rst_n_o), .sys_rst_out(rst_o),
    .wdog_expired_n_out(exp_n_o), .power_warn_n_out(warn_n_o));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic summarize();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // complement checked every cycle, not only at the scenario points
  always @(negedge clk) begin
    chk(rst_o, ~rst_n_o);
  end

  // run is under 600 cycles; 2000 leaves room
  initial begin
    #40000;
    fails++;
    summarize();
  end

  initial begin
    cyc(6);
    rst_n = 1'h1;
    foreach (rows[i]) begin
      man_n = rows[i].man;
      sup_low = rows[i].sup;
      sense = rows[i].sen;
      cyc(rows[i].wt);
      chk(rst_n_o, rows[i].rs);
      chk(exp_n_o, rows[i].ex);
      chk(warn_n_o, rows[i].wn);
    end
    // stall once at each kick level
    for (int i = 0; i < 2; i++) begin
      lv = kick;
      kick_en = 1'h1;
      for (int k = 0; k < 20 && kick === lv; k++) cyc(1);
      kick_en = 1'h0;
      cyc(WDT - 5);
      chk(exp_n_o, 1'h1);
      cyc(17);
      chk(exp_n_o, 1'h0);
      chk(rst_n_o, 1'h1);
    end
    flt = 1'h1;
    cyc(2 * WDT);
    chk(exp_n_o, 1'h1);
    flt = 1'h0;
    kick_en = 1'h1;
    cyc(10);
    chk(exp_n_o, 1'h1);
    // expiry reaches system reset only through the wiring
    tie = 1'h1;
    kick_en = 1'h0;
    cyc(WDT + 12);
    chk(rst_n_o, 1'h0);
    tie = 1'h0;
    kick_en = 1'h1;
    cyc(HOLD + 10);
    chk(rst_n_o, 1'h1);
    // second cause in mid-hold restarts the hold
    man_n = 1'h0;
    cyc(4);
    man_n = 1'h1;
    cyc(HOLD / 2);
    man_n = 1'h0;
    cyc(4);
    man_n = 1'h1;
    cyc(HOLD);
    chk(rst_n_o, 1'h0);
    cyc(8);
    chk(rst_n_o, 1'h1);
    // reset in mid-run
    rst_n = 1'h0;
    cyc(2);
    chk(rst_n_o, 1'h0);
    chk(exp_n_o, 1'h1);
    chk(warn_n_o, 1'h0);
    rst_n = 1'h1;
    cyc(10);
    chk(rst_n_o, 1'h0);
    cyc(HOLD + 5);
    chk(rst_n_o, 1'h1);
    summarize();
  end
endmodule // supply_supervisor_watchdog_tb
`default_nettype wire
